// File: ssc_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_write;
  logic             do_read;
  logic             full;
  logic             empty;

  assign full     = (count == (AW+1)'(DEPTH));
  assign empty    = (count == '0);
  assign in_ready = !full;
  assign do_write = in_valid && !full;
  // read data sits in a register, so valid waits one cycle after the pop
  assign do_read  = !empty && (!out_valid || out_ready);

  always_ff @(posedge clock) begin
    if (do_write) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (do_write) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_read) begin
        rd_ptr   <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      count <= count + (AW+1)'(do_write) - (AW+1)'(do_read);
      if (do_read) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : ssc_fifo
`default_nettype wire

// File: ssc_host.sv
/* Host model on the serial pins.
   Assumes the bench clock; serial period of 8 clocks. */
`timescale 1ns/1ps
`default_nettype none
module ssc_host (
  input  wire logic clock,
  output logic      serial_clock,
  output logic      serial_in,
  output logic      chip_select_n
);
  initial begin
    serial_clock = 1'b0;
    serial_in = 1'b0;
    chip_select_n = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_n
  // hold_hi leaves the clock high as select rises; data moves on the fall
  task automatic xfer(input logic [15:0] w, input int n, input bit hold_hi);
    chip_select_n <= 1'b0;
    wait_n(4);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= w[i];
      wait_n(4);
      serial_clock <= 1'b1;
      wait_n(4);
      if (i > 0 || !hold_hi) begin
        serial_clock <= 1'b0;
      end
    end
    if (!hold_hi) begin
      wait_n(4);
    end
    chip_select_n <= 1'b1;
    serial_in <= ~serial_in;
    wait_n(8);
  endtask : xfer
  task automatic clk_pulse;
    serial_clock <= 1'b1;
    wait_n(4);
    serial_clock <= 1'b0;
    wait_n(8);
  endtask : clk_pulse
  // select falls while the clock is still high, then the clock falls
  task automatic select_while_high;
    chip_select_n <= 1'b0;
    wait_n(8);
    serial_clock <= 1'b0;
    wait_n(8);
  endtask : select_while_high
endmodule : ssc_host
`default_nettype wire

// File: ssc_pkg.sv
/*
  Package for the serial switch control chain: word width, reset values
  and the latch update state encoding.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ssc_pkg;
  localparam int          SSC_WORD_WIDTH = 8;
  localparam int          SSC_TOP_BIT    = SSC_WORD_WIDTH - 1;
  localparam int          SSC_BOTTOM_BIT = 0;
  localparam logic [7:0]  SSC_WORD_RESET = 8'h00;
  localparam int          SSC_FIFO_DEPTH = 32;
  localparam int          SSC_SYNC_DEPTH = 2;
  // latch update sequencing
  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_WAIT_LOW,
    SSC_LOAD
  } ssc_update_type;
endpackage : ssc_pkg
`default_nettype wire

// File: ssc_switch_chain.sv
/*
  Serial control logic of an eight-switch array: shift register on the
  serial clock, latch updated on chip select rising, serial output for
  chaining, and a reset from the logic supply dip.
  Assumes serial pins arrive asynchronous to clock and are much slower
  (serial clock period well above 4 system clocks). Each latched word is
  also offered on a FIFO stream for the surrounding logic.
  The stream never stalls the latch: a word that finds the FIFO full is
  lost to the stream only, and word_dropped pulses for one cycle.
  The serial clock is only ever sampled, never used as a clock.
*/
// Contract
// - with chip select low, sample serial input on each serial clock rise
// - shift most significant bit first
// - serial output is last stage, updated on falling serial clock
// - latch loads on select rise only with clock low, else on next fall
// - each word bit drives matching switch, one closes, zero opens
// - on shared select rise every chained device latches together
// - select low, shift word, select high latches the word
// - differential use: two pulses four apart, latch, repeat to advance
// - logic supply dip opens all switches and clears shift register
`timescale 1ns/1ps
`default_nettype none
module ssc_switch_chain
  import ssc_pkg::*;
#(
  parameter int WIDTH      = ssc_pkg::SSC_WORD_WIDTH,
  parameter int FIFO_DEPTH = ssc_pkg::SSC_FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             logic_supply_reset,
  input  wire logic             serial_clock,
  input  wire logic             serial_in,
  input  wire logic             chip_select_n,
  output logic                  serial_out,
  output logic      [WIDTH-1:0] switch_closed,
  output logic      [WIDTH-1:0] shift_word,
  output logic                  word_valid,
  input  wire logic             word_ready,
  output logic      [WIDTH-1:0] word_data,
  output logic                  word_dropped
);
  import ssc_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // bit order of the pin vector below
  localparam int PIN_SCLK   = 0;
  localparam int PIN_DIN    = 1;
  localparam int PIN_CSN    = 2;
  localparam int PIN_SUPPLY = 3;
  localparam int PIN_COUNT  = 4;

  // idle levels of the pins, so that no false edge follows reset
  localparam logic SCLK_IDLE  = 1'b0;
  localparam logic CSN_IDLE   = 1'b1;
  localparam logic DOUT_RESET = 1'b0;

  // rising edge of a synchronised level against its one-cycle delay
  function automatic logic rose_now(input logic now_level, input logic last_level);
    rose_now = now_level && !last_level;
  endfunction : rose_now

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_s;
  logic                 sclk_prev;
  logic                 csn_prev;

  assign pin_raw[PIN_SCLK]   = serial_clock;
  assign pin_raw[PIN_DIN]    = serial_in;
  assign pin_raw[PIN_CSN]    = chip_select_n;
  assign pin_raw[PIN_SUPPLY] = logic_supply_reset;

  // every pin is asynchronous, so each passes two flops before any logic
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
    logic [SSC_SYNC_DEPTH-1:0] stage;
    always_ff @(posedge clock) begin
      stage <= {stage[SSC_SYNC_DEPTH-2:0], pin_raw[p]};
    end
    assign pin_s[p] = stage[SSC_SYNC_DEPTH-1];
  end

  logic sclk_s;
  logic din_s;
  logic csn_s;
  logic clear_all;
  logic sclk_rise;
  logic sclk_fall;
  logic csn_rise;

  assign sclk_s    = pin_s[PIN_SCLK];
  assign din_s     = pin_s[PIN_DIN];
  assign csn_s     = pin_s[PIN_CSN];
  // active-high reset request: the supply has dipped below threshold
  assign clear_all = rst || pin_s[PIN_SUPPLY];
  assign sclk_rise = rose_now(sclk_s, sclk_prev);
  assign sclk_fall = rose_now(sclk_prev, sclk_s);
  assign csn_rise  = rose_now(csn_s, csn_prev);

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev <= SCLK_IDLE;
      csn_prev  <= CSN_IDLE;
    end else begin
      sclk_prev <= sclk_s;
      csn_prev  <= csn_s;
    end
  end

  // ---------------------------------------------------------------
  // shift register and serial output
  // ---------------------------------------------------------------
  logic             shift_en;
  logic [WIDTH-1:0] next_shift;

  assign shift_en   = !csn_s && sclk_rise;
  assign next_shift = {shift_word[WIDTH-2:0], din_s};

  always_ff @(posedge clock) begin
    if (clear_all) begin
      shift_word <= WIDTH'(SSC_WORD_RESET);
    end else if (shift_en) begin
      shift_word <= next_shift;
    end
  end

  // output moves on the fall so a chained neighbour samples a stable bit
  always_ff @(posedge clock) begin
    if (clear_all) begin
      serial_out <= DOUT_RESET;
    end else if (!csn_s && sclk_fall) begin
      serial_out <= shift_word[WIDTH-1];
    end
  end

  // ---------------------------------------------------------------
  // latch update sequencing
  // ---------------------------------------------------------------
  ssc_update_type state;
  ssc_update_type next_state;

  // a select rise seen with the clock high defers the load to the fall;
  // a new select fall meanwhile cancels it so no partial word lands
  always_comb begin
    next_state = state;
    unique case (state)
      SSC_IDLE: begin
        if (csn_rise) begin
          next_state = sclk_s ? SSC_WAIT_LOW : SSC_LOAD;
        end
      end
      SSC_WAIT_LOW: begin
        if (!csn_s) begin
          next_state = SSC_IDLE;
        end else if (!sclk_s) begin
          next_state = SSC_LOAD;
        end
      end
      SSC_LOAD: begin
        next_state = SSC_IDLE;
      end
      // the fourth code of the state register is never entered
      default: begin
        next_state = SSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (clear_all) begin
      state <= SSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // a load lands with select high, so the word cannot move under it
  logic load_now;
  assign load_now = (state == SSC_LOAD);

  always_ff @(posedge clock) begin
    if (clear_all) begin
      switch_closed <= WIDTH'(SSC_WORD_RESET);
    end else if (load_now) begin
      switch_closed <= shift_word;
    end
  end

  // ---------------------------------------------------------------
  // latched word stream
  // ---------------------------------------------------------------
  logic fifo_in_ready;

  // holds DEPTH words plus one more in its output register
  ssc_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (clear_all),
    .in_valid  (load_now),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_word),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  // the switches must never stall for the stream, so overflow is flagged
  always_ff @(posedge clock) begin
    if (clear_all) begin
      word_dropped <= 1'b0;
    end else begin
      word_dropped <= load_now && !fifo_in_ready;
    end
  end
endmodule : ssc_switch_chain
`default_nettype wire

// File: ssc_switch_chain_props.sv
/* Port checker of the switch chain.
   Assumes binding into ssc_switch_chain. */
`timescale 1ns/1ps
`default_nettype none
module ssc_switch_chain_props #(
  parameter int WIDTH = 8
) (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             logic_supply_reset,
  input wire logic             serial_clock,
  input wire logic             chip_select_n,
  input wire logic             serial_out,
  input wire logic [WIDTH-1:0] switch_closed,
  input wire logic [WIDTH-1:0] shift_word
);
  logic [3:0] sup_cnt;
  wire logic  quiet = (sup_cnt == 4'h0);
  // supply dips act through a synchroniser, so mask their settling window
  always_ff @(posedge clock) begin
    if (rst || logic_supply_reset) sup_cnt <= 4'h8;
    else if (!quiet) sup_cnt <= sup_cnt - 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rise_low;
    $rose(chip_select_n) && !serial_clock && quiet ##1 (chip_select_n && !serial_clock && quiet)[*5];
  endsequence
  sequence s_rise_high;
    $rose(chip_select_n) && serial_clock ##1 (chip_select_n && serial_clock && quiet)[*4];
  endsequence
  a_supply_clear: assert property (logic_supply_reset[*5] |-> switch_closed == '0 && shift_word == '0)
    else $error("supply dip did not clear");
  a_shift_idle: assert property ((chip_select_n && quiet)[*6] |-> $stable(shift_word))
    else $error("shift while deselected");
  a_latch_steady: assert property ((!chip_select_n && quiet)[*6] |-> $stable(switch_closed))
    else $error("switches moved while shifting");
  a_shift_msb: assert property ($changed(shift_word) && quiet |-> shift_word[WIDTH-1:1] == $past(shift_word[WIDTH-2:0]))
    else $error("bad shift step");
  a_out_stage: assert property ($changed(serial_out) && quiet |-> serial_out == $past(shift_word[WIDTH-1]))
    else $error("serial out not last stage");
  a_latch_copy: assert property ($changed(switch_closed) && quiet |-> switch_closed == $past(shift_word) && chip_select_n)
    else $error("latch took wrong word");
  a_load_now: assert property (s_rise_low |-> switch_closed == shift_word)
    else $error("latch not loaded");
  a_load_wait: assert property (s_rise_high |-> switch_closed == $past(switch_closed, 4))
    else $error("latch loaded with clock high");
endmodule : ssc_switch_chain_props
bind ssc_switch_chain ssc_switch_chain_props #(.WIDTH(WIDTH)) props_u (.clock(clock), .rst(rst),
  .logic_supply_reset(logic_supply_reset), .serial_clock(serial_clock), .chip_select_n(chip_select_n),
  .serial_out(serial_out), .switch_closed(switch_closed), .shift_word(shift_word));
`default_nettype wire

// File: ssc_switch_chain_test.sv
/* Bench of the switch chain.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module ssc_switch_chain_test;
  logic       clock, rst, logic_supply_reset, word_ready;
  wire logic  serial_clock, serial_in, chip_select_n, serial_out, word_valid, word_dropped;
  wire logic [7:0] switch_closed, shift_word, word_data;
  int         bad_count, checks, pops, p0;
  logic       dropped_seen;
  logic [7:0] last_word;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ssc_host host_u (.clock(clock), .serial_clock(serial_clock), .serial_in(serial_in),
    .chip_select_n(chip_select_n));
  ssc_switch_chain dut_u (.clock(clock), .rst(rst), .logic_supply_reset(logic_supply_reset),
    .serial_clock(serial_clock), .serial_in(serial_in), .chip_select_n(chip_select_n),
    .serial_out(serial_out), .switch_closed(switch_closed), .shift_word(shift_word),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data), .word_dropped(word_dropped));
  always @(posedge clock) begin
    if (word_valid === 1'b1 && word_ready) begin
      pops++;
      last_word = word_data;
    end
    if (word_dropped === 1'b1) dropped_seen = 1'b1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial begin
    rst = 1'b1;
    logic_supply_reset = 1'b0;
    word_ready = 1'b1;
    dropped_seen = 1'b0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    host_u.wait_n(6);
    chk(switch_closed, 8'h00);
    host_u.xfer(16'h00A5, 8, 1'b0);
    chk(switch_closed, 8'hA5);
    chk(last_word, 8'hA5);
    host_u.xfer(16'h5AC3, 16, 1'b0);
    chk(switch_closed, 8'hC3);
    chk({7'h00, serial_out}, 8'h01);
    host_u.xfer(16'h0033, 8, 1'b1);
    chk(switch_closed, 8'hC3);
    host_u.clk_pulse();
    chk(switch_closed, 8'h33);
    host_u.clk_pulse();
    chk(shift_word, 8'h33);
    host_u.xfer(16'h0000, 8, 1'b0);
    chk(switch_closed, 8'h00);
    for (int i = 0; i < 8; i++) begin
      host_u.xfer({15'h0000, i == 0}, 1, 1'b0);
      chk(switch_closed, 8'h01 << i);
    end
    host_u.xfer(16'h0001, 4, 1'b0);
    host_u.xfer(16'h0001, 4, 1'b0);
    chk(switch_closed, 8'h11);
    host_u.xfer(16'h0000, 1, 1'b0);
    chk(switch_closed, 8'h22);
    // a deferred load is dropped when select falls before the clock does
    host_u.xfer(16'h00F0, 8, 1'b1);
    chk(switch_closed, 8'h22);
    host_u.select_while_high();
    chk(switch_closed, 8'h22);
    host_u.xfer(16'h0000, 1, 1'b0);
    chk(switch_closed, 8'hE0);
    chk({7'h00, serial_out}, 8'h01);
    logic_supply_reset <= 1'b1;
    host_u.wait_n(6);
    logic_supply_reset <= 1'b0;
    host_u.wait_n(6);
    chk(switch_closed, 8'h00);
    chk(shift_word, 8'h00);
    chk({7'h00, serial_out}, 8'h00);
    // stall the consumer until the stream buffer overflows
    word_ready <= 1'b0;
    p0 = pops;
    for (int i = 0; i < 34; i++) host_u.xfer(16'h0000, 1, 1'b0);
    chk({7'h00, dropped_seen}, 8'h01);
    word_ready <= 1'b1;
    host_u.wait_n(100);
    // 32 words in the buffer plus the one held in its output register
    chk(8'(pops - p0), 8'h21);
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    results();
  end
endmodule : ssc_switch_chain_test
`default_nettype wire
